// >>> design/kpi_pkg.sv
// constants and types shared by the keypad pin interrupt unit
// Functional notes
// - read-only pending flag shows the latched request, unaffected by mask, reset clears it
// - a set pin enable bit forces that pin to be an input
// - port data read returns the live pin only when its direction bit is 0
// - status/control register at index 1A, pin enable register at index 1B
// - writing 1 to the acknowledge bit clears the request; it reads 0
// - mask bit 1 blocks the request from the processor; reset clears it
// - sensitivity bit: 1 edges and low levels, 0 edges only; reset clears
// - eight enable bits include or exclude each pin; reset clears them
// - the unit runs in wait mode and unmasked requests wake the processor
// - the unit runs in stop mode and unmasked requests wake the processor
// - in break with break clear enable 1, acknowledge clears and stays cleared
// - in break with break clear enable 0, acknowledge writes do nothing
// - latch when enabled pins go low after all were high
// - level mode clears only after acknowledge and all enabled pins high
// - edge mode: vector fetch or acknowledge clears at once; reset clears
// - a set pin enable bit also turns on the pin pull-up
package kpi_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PINS   = 8;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_STATUS_CTRL = 6'h1A;
	localparam logic [5:0] IDX_PIN_ENABLE  = 6'h1B;
	localparam logic [5:0] IDX_PORT_DATA   = 6'h1C;
	localparam logic [5:0] IDX_PORT_DIR    = 6'h1D;

	// status/control field positions
	localparam int unsigned BIT_MODE = 0;
	localparam int unsigned BIT_MASK = 1;
	localparam int unsigned BIT_ACK  = 2;
	localparam int unsigned BIT_FLAG = 3;

	// reset values
	localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
	localparam logic [7:0] RST_PORT_DATA  = 8'h00;
	localparam logic [7:0] RST_PORT_DIR   = 8'h00;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// control bits of the status/control register
	typedef struct packed {
		logic mask;
		logic mode;
	} kpi_ctrl_s;

	localparam kpi_ctrl_s RST_CTRL = '{mask: 1'b0, mode: 1'b0};

endpackage : kpi_pkg

// >>> design/kpi_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module kpi_sync #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;

	// first stage read only by the second; idle pins read high
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '1;
			sync_o <= '1;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : kpi_sync

// >>> design/kpi_req_latch.sv
// keypad request latch with edge and edge-and-level triggering
`timescale 1ns/1ns
module kpi_req_latch (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// synchronised pins and setup
	input  wire logic [7:0] pins_i,
	input  wire logic [7:0] enable_i,
	input  wire logic       level_mode_i,
	// acknowledges, already qualified
	input  wire logic       ack_i,
	// latched request
	output logic            req_o
);

	logic any_low;
	logic fall;
	logic clear;
	logic low_q;
	logic ackd_q;

	// one enabled low pin after all enabled pins were high sets the latch
	assign any_low = |(~pins_i & enable_i);
	assign fall    = any_low & ~low_q;
	// level mode waits for both ack and all pins high, in either order
	assign clear   = level_mode_i ? ((ack_i | ackd_q) & ~any_low) : ack_i;

	// set wins over clear so an edge in the ack cycle is kept
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_q  <= 1'b0;
			req_o  <= 1'b0;
			ackd_q <= 1'b0;
		end else begin
			low_q  <= any_low;
			req_o  <= fall | (req_o & ~clear);
			ackd_q <= ~fall & req_o & ~clear & (ackd_q | ack_i);
		end
	end

endmodule : kpi_req_latch

// >>> design/kpi_top.sv
// keypad pin interrupt unit with axi4-lite register access
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
module kpi_top (
	// clock and reset
	input  wire logic                        CLK_I,
	input  wire logic                        RST_N_I,
	// axi4-lite write address
	input  wire logic                        AWVALID_I,
	output logic                             AWREADY_O,
	input  wire logic [kpi_pkg::ADDR_W-1:0]  AWADDR_I,
	input  wire logic [2:0]                  AWPROT_I,
	// axi4-lite write data
	input  wire logic                        WVALID_I,
	output logic                             WREADY_O,
	input  wire logic [kpi_pkg::DATA_W-1:0]  WDATA_I,
	input  wire logic [3:0]                  WSTRB_I,
	// axi4-lite write response
	output logic                             BVALID_O,
	input  wire logic                        BREADY_I,
	output logic [1:0]                       BRESP_O,
	// axi4-lite read address
	input  wire logic                        ARVALID_I,
	output logic                             ARREADY_O,
	input  wire logic [kpi_pkg::ADDR_W-1:0]  ARADDR_I,
	input  wire logic [2:0]                  ARPROT_I,
	// axi4-lite read data
	output logic                             RVALID_O,
	input  wire logic                        RREADY_I,
	output logic [kpi_pkg::DATA_W-1:0]       RDATA_O,
	output logic [1:0]                       RRESP_O,
	// keypad port pins
	input  wire logic [7:0]                  KEYPAD_INPUTS_I,
	output logic      [7:0]                  KEYPAD_PIN_O,
	output logic      [7:0]                  KEYPAD_PIN_OE_O,
	output logic      [7:0]                  KEYPAD_PULLUP_O,
	// processor side
	input  wire logic                        VECTOR_FETCH_I,
	input  wire logic                        BREAK_I,
	input  wire logic                        BREAK_CLEAR_ENABLE_I,
	input  wire logic                        WAIT_I,
	input  wire logic                        STOP_I,
	output logic                             IRQ_O,
	output logic                             WAKE_O
);

	// ---- register state ----
	kpi_pkg::kpi_ctrl_s ctrl_q;
	kpi_pkg::kpi_ctrl_s ctrl_d;
	logic [7:0]         pin_enable_q;
	logic [7:0]         pin_enable_d;
	logic [7:0]         port_data_q;
	logic [7:0]         port_data_d;
	logic [7:0]         port_dir_q;
	logic [7:0]         port_dir_d;

	// ---- write channel state ----
	logic                       aw_full_q;
	logic                       aw_full_d;
	logic [kpi_pkg::ADDR_W-1:0] aw_addr_q;
	logic                       w_full_q;
	logic                       w_full_d;
	logic [7:0]                 w_data_q;
	logic                       w_lane0_q;
	logic                       awready_q;
	logic                       wready_q;
	logic                       bvalid_q;
	logic                       bvalid_d;
	logic [1:0]                 bresp_q;

	// ---- read channel state ----
	logic                       arready_q;
	logic                       rvalid_q;
	logic                       rvalid_d;
	logic [7:0]                 rdata_q;
	logic [1:0]                 rresp_q;

	// ---- pin and request state ----
	logic [7:0] pins_sync;
	logic       req;
	logic       irq_q;
	logic       wake_q;
	logic [7:0] pin_o_q;
	logic [7:0] pin_oe_q;
	logic [7:0] pullup_q;

	// ---- decode wires ----
	logic       aw_take;
	logic       w_take;
	logic       wr_fire;
	logic [5:0] wr_idx;
	logic       wr_sc;
	logic       wr_en;
	logic       wr_data;
	logic       wr_dir;
	logic       wr_hit;
	logic       wr_byte;
	logic       ar_take;
	logic [5:0] rd_idx;
	logic       rd_sc;
	logic       rd_en;
	logic       rd_data;
	logic       rd_dir;
	logic       rd_hit;
	logic [7:0] sc_view;
	logic [7:0] data_view;
	logic [7:0] rd_mux;
	logic       ack_write;
	logic       ack_allowed;
	logic       ack_any;
	logic       irq_d;

	// protection bits carry no meaning here
	logic prot_unused;
	assign prot_unused = ^{AWPROT_I, ARPROT_I};

	// keypad pins cross into the bus clock before any edge logic
	kpi_sync #(
		.W (kpi_pkg::PINS)
	) u_pin_sync (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.async_i (KEYPAD_INPUTS_I),
		.sync_o  (pins_sync)
	);

	// write handshakes: address and data taken in either order
	// a write commits only once both beats are held and no response waits
	assign aw_take = AWVALID_I & awready_q;
	assign w_take  = WVALID_I & wready_q;
	assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;

	// write address decode on the held address
	assign wr_idx  = aw_addr_q[7:2];
	assign wr_sc   = (wr_idx == kpi_pkg::IDX_STATUS_CTRL);
	assign wr_en   = (wr_idx == kpi_pkg::IDX_PIN_ENABLE);
	assign wr_data = (wr_idx == kpi_pkg::IDX_PORT_DATA);
	assign wr_dir  = (wr_idx == kpi_pkg::IDX_PORT_DIR);
	assign wr_hit  = wr_sc | wr_en | wr_data | wr_dir;
	// registers live in byte lane 0; other lanes are ignored
	assign wr_byte = wr_fire & w_lane0_q;

	// acknowledge is honoured in break only when break clear is enabled
	assign ack_write   = wr_byte & wr_sc & w_data_q[kpi_pkg::BIT_ACK];
	assign ack_allowed = ~BREAK_I | BREAK_CLEAR_ENABLE_I;
	assign ack_any     = (ack_write & ack_allowed) | VECTOR_FETCH_I;

	// next register values; the ack bit itself is never stored
	always_comb begin
		ctrl_d       = ctrl_q;
		pin_enable_d = pin_enable_q;
		port_data_d  = port_data_q;
		port_dir_d   = port_dir_q;
		if (wr_byte && wr_sc) begin
			ctrl_d.mask = w_data_q[kpi_pkg::BIT_MASK];
			ctrl_d.mode = w_data_q[kpi_pkg::BIT_MODE];
		end
		if (wr_byte && wr_en) begin
			pin_enable_d = w_data_q;
		end
		if (wr_byte && wr_data) begin
			port_data_d = w_data_q;
		end
		if (wr_byte && wr_dir) begin
			port_dir_d = w_data_q;
		end
	end

	// channel occupancy; ready falls while a beat is held or answered
	assign aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
	assign w_full_d  = (w_full_q | w_take) & ~wr_fire;
	assign bvalid_d  = wr_fire | (bvalid_q & ~BREADY_I);

	// write channel occupancy and readies
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awready_q <= ~aw_full_d & ~bvalid_d;
			wready_q  <= ~w_full_d & ~bvalid_d;
		end
	end

	// write response; an unmapped index answers slverr and changes nothing
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			bvalid_q <= 1'b0;
			bresp_q  <= kpi_pkg::RESP_OKAY;
		end else begin
			bvalid_q <= bvalid_d;
			if (wr_fire) begin
				bresp_q <= wr_hit ? kpi_pkg::RESP_OKAY : kpi_pkg::RESP_SLVERR;
			end
		end
	end

	// write payload capture
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			aw_addr_q <= '0;
			w_data_q  <= 8'h00;
			w_lane0_q <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_addr_q <= AWADDR_I;
			end
			if (w_take) begin
				w_data_q  <= WDATA_I[7:0];
				w_lane0_q <= WSTRB_I[0];
			end
		end
	end

	// keypad control and enables; reset clears mask, mode and every enable
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_q       <= kpi_pkg::RST_CTRL;
			pin_enable_q <= kpi_pkg::RST_PIN_ENABLE;
		end else begin
			ctrl_q       <= ctrl_d;
			pin_enable_q <= pin_enable_d;
		end
	end

	// port data latch and direction
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			port_data_q <= kpi_pkg::RST_PORT_DATA;
			port_dir_q  <= kpi_pkg::RST_PORT_DIR;
		end else begin
			port_data_q <= port_data_d;
			port_dir_q  <= port_dir_d;
		end
	end

	// request latch runs on the bus clock, so it keeps working in wait
	// in stop the bus clock must keep running; the wake flop needs it too
	kpi_req_latch u_latch (
		.clk_i        (CLK_I),
		.rst_n_i      (RST_N_I),
		.pins_i       (pins_sync),
		.enable_i     (pin_enable_q),
		.level_mode_i (ctrl_q.mode),
		.ack_i        (ack_any),
		.req_o        (req)
	);

	// read decode; pending flag ignores the mask, ack reads zero
	assign ar_take   = ARVALID_I & arready_q;
	assign rd_idx    = ARADDR_I[7:2];
	assign rd_sc     = (rd_idx == kpi_pkg::IDX_STATUS_CTRL);
	assign rd_en     = (rd_idx == kpi_pkg::IDX_PIN_ENABLE);
	assign rd_data   = (rd_idx == kpi_pkg::IDX_PORT_DATA);
	assign rd_dir    = (rd_idx == kpi_pkg::IDX_PORT_DIR);
	assign rd_hit    = rd_sc | rd_en | rd_data | rd_dir;
	// status view from the named field positions; the ack bit has no storage
	always_comb begin
		sc_view                    = 8'h00;
		sc_view[kpi_pkg::BIT_FLAG] = req;
		sc_view[kpi_pkg::BIT_MASK] = ctrl_q.mask;
		sc_view[kpi_pkg::BIT_MODE] = ctrl_q.mode;
	end
	// live level only where direction is 0, even if forced to input
	assign data_view = (port_dir_q & port_data_q) | (~port_dir_q & pins_sync);
	// unmapped indices read as zero and answer slverr
	assign rd_mux    = rd_sc   ? sc_view      :
	                   rd_en   ? pin_enable_q :
	                   rd_data ? data_view    :
	                   rd_dir  ? port_dir_q   : 8'h00;
	assign rvalid_d  = ar_take | (rvalid_q & ~RREADY_I);

	// read channel handshake; one read in flight at a time
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
		end
	end

	// read payload, captured at the address handshake and held until taken
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_q <= 8'h00;
			rresp_q <= kpi_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				rdata_q <= rd_mux;
				rresp_q <= rd_hit ? kpi_pkg::RESP_OKAY : kpi_pkg::RESP_SLVERR;
			end
		end
	end

	// unmasked request drives the processor and wakes it from low power
	assign irq_d = req & ~ctrl_q.mask;

	// processor request and wake, each from its own flop
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			irq_q  <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			irq_q  <= irq_d;
			wake_q <= irq_d & (WAIT_I | STOP_I);
		end
	end

	// pin drive: enabled pins are inputs with pull-ups on
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pin_o_q  <= 8'h00;
			pin_oe_q <= 8'h00;
			pullup_q <= 8'h00;
		end else begin
			pin_o_q  <= port_data_q;
			pin_oe_q <= port_dir_q & ~pin_enable_q;
			pullup_q <= pin_enable_q;
		end
	end

	// outputs, all from flops
	// read data above the low byte is always zero
	assign AWREADY_O       = awready_q;
	assign WREADY_O        = wready_q;
	assign BVALID_O        = bvalid_q;
	assign BRESP_O         = bresp_q;
	assign ARREADY_O       = arready_q;
	assign RVALID_O        = rvalid_q;
	assign RDATA_O         = {24'h00_0000, rdata_q};
	assign RRESP_O         = rresp_q;
	assign KEYPAD_PIN_O    = pin_o_q;
	assign KEYPAD_PIN_OE_O = pin_oe_q;
	assign KEYPAD_PULLUP_O = pullup_q;
	assign IRQ_O           = irq_q;
	assign WAKE_O          = wake_q;

endmodule : kpi_top

// >>> verif/kpi_props.sv
// concurrent checks on the keypad interrupt unit ports
`timescale 1ns/1ns
module kpi_props (
	// clock and reset
	input wire logic        CLK_I,
	input wire logic        RST_N_I,
	// register bus
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic [7:0]  AWADDR_I,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [7:0]  ARADDR_I,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	input wire logic [31:0] RDATA_O,
	// pins and processor side
	input wire logic [7:0]  KEYPAD_PIN_OE_O,
	input wire logic [7:0]  KEYPAD_PULLUP_O,
	input wire logic        WAIT_I,
	input wire logic        STOP_I,
	input wire logic        IRQ_O,
	input wire logic        WAKE_O
);
	localparam logic [7:0] A_SC = {kpi_pkg::IDX_STATUS_CTRL, 2'b00};
	localparam logic [7:0] A_EN = {kpi_pkg::IDX_PIN_ENABLE, 2'b00};

	logic [7:0] aw_q, ar_q, wd_q, en_q;
	logic       bv_q, mask_q;
	// mirror lags the design by one edge, so checks wait for a quiet response channel
	wire        commit = BVALID_O && !bv_q;
	wire        quiet  = !BVALID_O && !bv_q;

	// mirror of mask and pin enables taken from committed writes
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			{aw_q, ar_q, wd_q, en_q, bv_q, mask_q} <= '0;
		end else begin
			bv_q <= BVALID_O;
			if (AWVALID_I && AWREADY_O) aw_q <= AWADDR_I;
			if (WVALID_I && WREADY_O) wd_q <= WDATA_I[7:0];
			if (ARVALID_I && ARREADY_O) ar_q <= ARADDR_I;
			if (commit && aw_q == A_SC) mask_q <= wd_q[kpi_pkg::BIT_MASK];
			if (commit && aw_q == A_EN) en_q <= wd_q;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	property p_rst;
		$rose(RST_N_I) |-> !IRQ_O && !WAKE_O && !BVALID_O && !RVALID_O;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs busy after reset");
	property p_wake;
		WAKE_O == (IRQ_O && $past(WAIT_I || STOP_I));
	endproperty
	a_wake: assert property (p_wake) else $error("wake mismatch");
	property p_mask;
		quiet && mask_q |-> !IRQ_O;
	endproperty
	a_mask: assert property (p_mask) else $error("masked request reached irq");
	property p_pull;
		quiet |-> KEYPAD_PULLUP_O == en_q;
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up differs from enables");
	property p_oe;
		quiet |-> (KEYPAD_PIN_OE_O & en_q) == 8'h00;
	endproperty
	a_oe: assert property (p_oe) else $error("enabled pin driven");
	property p_ack;
		RVALID_O && ar_q == A_SC |-> !RDATA_O[kpi_pkg::BIT_ACK];
	endproperty
	a_ack: assert property (p_ack) else $error("ack bit read as 1");
	property p_bhold;
		BVALID_O && !BREADY_I |=> BVALID_O;
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
	property p_rhold;
		RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
endmodule : kpi_props

bind kpi_top kpi_props i_kpi_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .AWVALID_I(AWVALID_I),
	.AWREADY_O(AWREADY_O), .AWADDR_I(AWADDR_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .WDATA_I(WDATA_I),
	.BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .ARADDR_I(ARADDR_I),
	.RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O), .KEYPAD_PIN_OE_O(KEYPAD_PIN_OE_O),
	.KEYPAD_PULLUP_O(KEYPAD_PULLUP_O), .WAIT_I(WAIT_I), .STOP_I(STOP_I), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O));

// >>> verif/kpi_keys.sv
// keypad switch model on the eight shared port pins
`timescale 1ns/1ns
module kpi_keys (
	// clock
	input  wire logic       clk_i,
	// switches, 1 = pressed
	input  wire logic [7:0] press_i,
	// drive and pull-up from the unit
	input  wire logic [7:0] pin_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] pullup_i,
	// resolved pin levels
	output logic      [7:0] level_o
);
	// floating pins wander so a stale level never looks valid
	logic [7:0] float_q = 8'h5A;
	always @(posedge clk_i) float_q <= ~float_q;
	// unit drive wins, a pressed switch grounds the pin, else pull-up or noise
	assign level_o = (oe_i & pin_i) | (~oe_i & ~press_i & (pullup_i | float_q));
endmodule : kpi_keys

// >>> verif/testbench.sv
// self-checking bench for the keypad pin interrupt unit
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
	localparam logic [7:0]  A_SC = {kpi_pkg::IDX_STATUS_CTRL, 2'b00};
	localparam logic [7:0]  A_EN = {kpi_pkg::IDX_PIN_ENABLE, 2'b00};
	localparam logic [7:0]  A_PD = {kpi_pkg::IDX_PORT_DATA, 2'b00};
	localparam logic [7:0]  A_DR = {kpi_pkg::IDX_PORT_DIR, 2'b00};
	localparam logic [1:0]  OK   = kpi_pkg::RESP_OKAY;
	localparam logic [31:0] ACK  = 32'h0000_0001 << kpi_pkg::BIT_ACK;
	localparam logic [31:0] MSK  = 32'h0000_0001 << kpi_pkg::BIT_MASK;
	localparam logic [31:0] MOD  = 32'h0000_0001 << kpi_pkg::BIT_MODE;
	logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic        vf = 0, brk = 0, bce = 0, wt = 0, sp = 0;
	logic [7:0]  awa = 0, ara = 0, keys = 0, en, d, ka, kb;
	logic [31:0] wdat = 0;
	integer      seed, fails = 0, checks_done = 0;
	wire         awr, wrd, bv, arr, rv, irq, wake;
	wire  [1:0]  br, rr;
	wire  [31:0] rdat;
	wire  [7:0]  pin, oe, pull, lvl;

	kpi_top i_kpi_top (.CLK_I(clk), .RST_N_I(rst_n), .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa),
		.AWPROT_I(3'h0), .WVALID_I(wv), .WREADY_O(wrd), .WDATA_I(wdat), .WSTRB_I(4'hF), .BVALID_O(bv),
		.BREADY_I(bre), .BRESP_O(br), .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara), .ARPROT_I(3'h0),
		.RVALID_O(rv), .RREADY_I(rre), .RDATA_O(rdat), .RRESP_O(rr), .KEYPAD_INPUTS_I(lvl), .KEYPAD_PIN_O(pin),
		.KEYPAD_PIN_OE_O(oe), .KEYPAD_PULLUP_O(pull), .VECTOR_FETCH_I(vf), .BREAK_I(brk),
		.BREAK_CLEAR_ENABLE_I(bce), .WAIT_I(wt), .STOP_I(sp), .IRQ_O(irq), .WAKE_O(wake));
	kpi_keys i_kpi_keys (.clk_i(clk), .press_i(keys), .pin_i(pin), .oe_i(oe), .pullup_i(pull), .level_o(lvl));

	// 50 MHz clock
	always #10 clk = ~clk;

	// expected status word
	function automatic logic [31:0] sc(input logic f, input logic m, input logic md);
		return (32'(f) << kpi_pkg::BIT_FLAG) | (32'(m) << kpi_pkg::BIT_MASK) | (32'(md) << kpi_pkg::BIT_MODE);
	endfunction : sc

	// one write; bready after a random stall so the held response is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ad;
		logic wdn;
		{ad, wdn} = 2'b00;
		@(posedge clk);
		{awv, wv, awa, wdat} <= {2'b11, a, v};
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			ad = ad | awr;
			wdn = wdn | wrd;
		end while (!(ad && wdn));
		repeat ($unsigned($random(seed)) % 3) @(posedge clk);
		bre <= 1'b1;
		do @(posedge clk); while (!bv);
		bre <= 1'b0;
		`CHK("bresp", er, br)
	endtask : wr

	// one read compared against its expectation
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		{arv, ara} <= {1'b1, a};
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		repeat ($unsigned($random(seed)) % 3) @(posedge clk);
		rre <= 1'b1;
		do @(posedge clk); while (!rv);
		rre <= 1'b0;
		`CHK("rdata", e, rdat)
		`CHK("rresp", er, rr)
	endtask : rd

	// set switches, then allow sync, latch and irq flops to settle
	task automatic press(input logic [7:0] k);
		keys <= k;
		repeat (5) @(posedge clk);
	endtask : press

	task automatic finish_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test

	// hang guard, far beyond the expected run
	initial begin
		#200_000;
		fails++;
		finish_test;
	end

	// main sequence
	initial begin
		seed = 27;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_SC, sc(0, 0, 0), OK);
		rd(A_EN, 32'h0000_0000, OK);
		rd(8'h00, 32'h0000_0000, kpi_pkg::RESP_SLVERR);
		en = 8'($random(seed));
		wr(A_DR, 32'h0000_00F0, OK);
		wr(A_EN, {24'h00_0000, en}, OK);
		rd(A_EN, {24'h00_0000, en}, OK);
		`CHK("pullup", en, pull)
		`CHK("oe", 8'hF0 & ~en, oe)
		d = 8'($random(seed));
		// pins 5:4 enabled yet set as outputs: reads give the latch, not the pulled-up pin
		wr(A_EN, 32'h0000_003F, OK);
		wr(A_PD, {24'h00_0000, d[7:6], 2'b00, d[3:0]}, OK);
		press(8'h01);
		rd(A_PD, {24'h00_0000, d[7:6], 2'b00, 4'hE}, OK);
		`CHK("oe", 8'hC0, oe)
		`CHK("pin", {d[7:6], 2'b00, d[3:0]}, pin)
		press(8'h00);
		wr(A_PD, 32'h0000_00FF, OK);
		wr(A_DR, 32'h0000_00FF, OK);
		wr(A_EN, 32'h0000_00FF, OK);
		wr(A_DR, 32'h0000_0000, OK);
		wr(A_SC, MSK, OK);
		wr(A_SC, MSK | ACK, OK);
		wr(A_SC, 32'h0000_0000, OK);
		rd(A_SC, sc(0, 0, 0), OK);
		ka = 8'h01 << ($unsigned($random(seed)) % 8);
		kb = {ka[4:0], ka[7:5]};
		press(ka);
		`CHK("irq", 1'b1, irq)
		rd(A_SC, sc(1, 0, 0), OK);
		wr(A_SC, ACK, OK);
		press(ka | kb);
		`CHK("irq", 1'b0, irq)
		press(8'h00);
		press(kb);
		`CHK("irq", 1'b1, irq)
		vf <= 1'b1;
		@(posedge clk);
		vf <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("irq", 1'b0, irq)
		press(8'h00);
		wr(A_SC, MSK, OK);
		press(ka);
		`CHK("irq", 1'b0, irq)
		rd(A_SC, sc(1, 1, 0), OK);
		wr(A_SC, ACK, OK);
		press(8'h00);
		for (int i = 0; i < 2; i++) begin
			{sp, wt} <= (i == 0) ? 2'b01 : 2'b10;
			press(ka);
			`CHK("wake", 1'b1, wake)
			wr(A_SC, ACK, OK);
			{sp, wt} <= 2'b00;
			press(8'h00);
		end
		wr(A_SC, MOD, OK);
		press(ka);
		wr(A_SC, MOD | ACK, OK);
		repeat (3) @(posedge clk);
		`CHK("irq", 1'b1, irq)
		press(8'h00);
		`CHK("irq", 1'b0, irq)
		// other order: keys released first, the request waits for the ack
		press(ka);
		press(8'h00);
		`CHK("irq", 1'b1, irq)
		wr(A_SC, MOD | ACK, OK);
		press(8'h00);
		`CHK("irq", 1'b0, irq)
		rd(A_SC, sc(0, 0, 1), OK);
		wr(A_SC, 32'h0000_0000, OK);
		brk <= 1'b1;
		press(ka);
		wr(A_SC, ACK, OK);
		rd(A_SC, sc(1, 0, 0), OK);
		bce <= 1'b1;
		wr(A_SC, ACK, OK);
		{brk, bce} <= 2'b00;
		rd(A_SC, sc(0, 0, 0), OK);
		press(8'h00);
		press(ka);
		`CHK("irq", 1'b1, irq)
		// reset in mid-run with the key still held down
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		`CHK("irq", 1'b0, irq)
		`CHK("pullup", 8'h00, pull)
		rd(A_SC, sc(0, 0, 0), OK);
		finish_test;
	end
endmodule : testbench
